// ==== cosoc_pkg.sv ====
// Package for the clamp, offset and sync-out control block.
// Assumes word-aligned AHB-Lite access; register index = byte address / 4.
package cosoc_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_COAST_CLAMP = 8'h18;
  localparam logic [7:0] IDX_START_DELAY = 8'h19;
  localparam logic [7:0] IDX_WIDTH_COUNT = 8'h1A;
  localparam logic [7:0] IDX_POL_OFFSET = 8'h1B;
  localparam logic [7:0] IDX_TEST_ZERO = 8'h1C;
  localparam logic [7:0] IDX_GSYNC_CTRL = 8'h1D;
  localparam logic [7:0] IDX_INPUT_POWER = 8'h1E;
  localparam logic [7:0] IDX_STATUS = 8'h30;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_COAST_CLAMP = 8'h20;
  localparam logic [7:0] RST_START_DELAY = 8'h08;
  localparam logic [7:0] RST_WIDTH_COUNT = 8'h20;
  localparam logic [7:0] RST_POL_OFFSET = 8'h5B;
  localparam logic [7:0] RST_TEST_ZERO = 8'hFF;
  localparam logic [7:0] RST_GSYNC_CTRL = 8'h78;
  localparam logic [7:0] RST_INPUT_POWER = 8'h30;
  // ==========================================================
  // Field positions
  localparam int B_CLAMP_SRC = 4;
  localparam int B_RED_MID = 3;
  localparam int B_GRN_MID = 2;
  localparam int B_BLU_MID = 1;
  localparam int B_POL_OVR = 7;
  localparam int B_POL = 6;
  localparam int B_AO_EN = 5;
  localparam int B_RATE_HI = 4;
  localparam int B_RATE_LO = 3;
  localparam int B_GS_POL = 2;
  localparam int B_GS_SEL_HI = 1;
  localparam int B_GS_SEL_LO = 0;
  localparam int B_CH_OVR = 7;
  localparam int B_CH_SEL = 6;
  localparam int B_PD_AUTO = 4;
  localparam int B_PD = 3;
  localparam int B_PD_PIN_POL = 2;
  // ==========================================================
  // Update rates and sync-out source selects
  localparam logic [1:0] RATE_3 = 2'h0;
  localparam logic [1:0] RATE_48 = 2'h1;
  localparam logic [1:0] RATE_192 = 2'h2;
  localparam logic [7:0] CLAMPS_3 = 8'h02;
  localparam logic [7:0] CLAMPS_48 = 8'h2F;
  localparam logic [7:0] CLAMPS_192 = 8'hBF;
  localparam logic [7:0] VSYNCS_3 = 8'h02;
  localparam logic [1:0] GS_RAW_GREEN = 2'h0;
  localparam logic [1:0] GS_RAW_HSYNC = 2'h1;
  localparam logic [1:0] GS_REGEN = 2'h2;
  // ==========================================================
  // Bus constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// ==== cosoc_ctrl.sv ====
// Clamp generator, auto-offset pacing, sync-on-green output routing,
// channel select and power-down control behind an AHB-Lite slave.
// Assumes: one clock hclk; pins are asynchronous and synchronised here;
// regenerated/filtered hsync and sync-activity flags come from logic on hclk.
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module cosoc_ctrl
  import cosoc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] horiz_sync_pin,
  input wire logic [1:0] green_sync_in_pin,
  input wire logic ext_clamp_pin,
  input wire logic vsync_pin,
  input wire logic pwrdn_pin,
  input wire logic regen_hsync,
  input wire logic filtered_hsync,
  input wire logic [1:0] sync_present,
  output logic clamp_out,
  output logic red_clamp_mid,
  output logic green_clamp_mid,
  output logic blue_clamp_mid,
  output logic auto_offset_en,
  output logic offset_update,
  output logic green_sync_out_pin,
  output logic channel_sel,
  output logic power_down
);
  // Assertions below share this clock and reset
  default clocking assert_clk @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // Pin synchronisers (two flops; stage one feeds stage two only)
  logic [6:0] pin_s1_r;
  logic [6:0] pin_s2_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= 7'h00;
      pin_s2_r <= 7'h00;
    end else begin
      pin_s1_r <= {pwrdn_pin, vsync_pin, ext_clamp_pin, green_sync_in_pin,
                   horiz_sync_pin};
      pin_s2_r <= pin_s1_r;
    end
  end
  wire logic [1:0] hs_sync = pin_s2_r[1:0];
  wire logic [1:0] gs_sync = pin_s2_r[3:2];
  wire logic ext_clamp_sync = pin_s2_r[4];
  wire logic vsync_sync = pin_s2_r[5];
  wire logic pwrdn_sync = pin_s2_r[6];

  // ==========================================================
  // Registers
  logic [7:0] coast_clamp_ctrl_r;
  logic [7:0] clamp_start_delay_r;
  logic [7:0] clamp_width_count_r;
  logic [7:0] clamp_polarity_autooffset_ctrl_r;
  logic [7:0] test_reg_zero_r;
  logic [7:0] green_sync_output_ctrl_r;
  logic [7:0] input_power_ctrl_r;

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  wire logic [7:0] ap_idx = haddr[9:2];
  wire logic ap_valid = hsel && hready && htrans == HTRANS_NONSEQ;
  wire logic ap_read = ap_valid && !hwrite;
  wire logic ap_write = ap_valid && hwrite;
  // A write still in its data phase is forwarded to a read of the same index right behind it
  wire logic fwd = wr_pend_r && wr_idx_r == ap_idx;
  wire logic [7:0] status_byte;
  wire logic [7:0] reg_rd;
  assign reg_rd =
    fwd ? hwdata[7:0] :
    ap_idx == IDX_COAST_CLAMP ? coast_clamp_ctrl_r :
    ap_idx == IDX_START_DELAY ? clamp_start_delay_r :
    ap_idx == IDX_WIDTH_COUNT ? clamp_width_count_r :
    ap_idx == IDX_POL_OFFSET ? clamp_polarity_autooffset_ctrl_r :
    ap_idx == IDX_TEST_ZERO ? test_reg_zero_r :
    ap_idx == IDX_GSYNC_CTRL ? green_sync_output_ctrl_r :
    ap_idx == IDX_INPUT_POWER ? input_power_ctrl_r :
    ap_idx == IDX_STATUS ? status_byte : 8'h00;
  wire logic [31:0] rd_word = {24'h000000, reg_rd};

  // Bus phase tracking and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      hrdata <= RDATA_ZERO;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= ap_write;
      wr_idx_r <= ap_idx;
      hrdata <= ap_read ? rd_word : RDATA_ZERO;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Register writes land in the data phase; unmapped indices are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coast_clamp_ctrl_r <= RST_COAST_CLAMP;
      clamp_start_delay_r <= RST_START_DELAY;
      clamp_width_count_r <= RST_WIDTH_COUNT;
      clamp_polarity_autooffset_ctrl_r <= RST_POL_OFFSET;
      test_reg_zero_r <= RST_TEST_ZERO;
      green_sync_output_ctrl_r <= RST_GSYNC_CTRL;
      input_power_ctrl_r <= RST_INPUT_POWER;
    end else if (wr_pend_r) begin
      if (wr_idx_r == IDX_COAST_CLAMP) begin
        coast_clamp_ctrl_r <= hwdata[7:0]; // Bit 0 kept zero by software
      end else if (wr_idx_r == IDX_START_DELAY) begin
        clamp_start_delay_r <= hwdata[7:0];
      end else if (wr_idx_r == IDX_WIDTH_COUNT) begin
        clamp_width_count_r <= hwdata[7:0];
      end else if (wr_idx_r == IDX_POL_OFFSET) begin
        clamp_polarity_autooffset_ctrl_r <= hwdata[7:0]; // Low bits 011
      end else if (wr_idx_r == IDX_TEST_ZERO) begin
        test_reg_zero_r <= hwdata[7:0]; // Stored only, kept all ones
      end else if (wr_idx_r == IDX_GSYNC_CTRL) begin
        green_sync_output_ctrl_r <= hwdata[7:0];
      end else if (wr_idx_r == IDX_INPUT_POWER) begin
        input_power_ctrl_r <= hwdata[7:0];
      end
    end
  end

  // ==========================================================
  // Channel selection
  wire logic both_present = &sync_present;
  wire logic ch_manual = input_power_ctrl_r[B_CH_OVR] || both_present;
  // Left alone, the device follows whichever channel carries sync
  wire logic ch_nxt = ch_manual ? input_power_ctrl_r[B_CH_SEL] :
                      (sync_present == 2'h2);
  wire logic hs_sel = hs_sync[channel_sel];
  wire logic gs_sel = gs_sync[channel_sel];

  // ==========================================================
  // Internal clamp generator
  logic hs_d_r;
  logic vs_d_r;
  logic pend_r;
  logic clamp_int_r;
  logic [7:0] delay_cnt_r;
  logic [7:0] width_cnt_r;
  // Hsync is taken as active high here; its fall is the trailing edge
  wire logic hs_fall = hs_d_r && !hs_sel;
  wire logic vs_rise = vsync_sync && !vs_d_r;
  wire logic width_zero = clamp_width_count_r == 8'h00;

  // Each trailing edge aborts any clamp in progress and restarts placement
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_d_r <= 1'b0;
      vs_d_r <= 1'b0;
      pend_r <= 1'b0;
      clamp_int_r <= 1'b0;
      delay_cnt_r <= 8'h00;
      width_cnt_r <= 8'h00;
    end else begin
      hs_d_r <= hs_sel;
      vs_d_r <= vsync_sync;
      if (hs_fall) begin
        pend_r <= 1'b1;
        clamp_int_r <= 1'b0;
        delay_cnt_r <= clamp_start_delay_r;
      end else if (pend_r) begin
        if (delay_cnt_r == 8'h00) begin
          pend_r <= 1'b0;
          clamp_int_r <= !width_zero;
          width_cnt_r <= clamp_width_count_r - 8'h01;
        end else begin
          delay_cnt_r <= delay_cnt_r - 8'h01;
        end
      end else if (clamp_int_r) begin
        if (width_cnt_r == 8'h00) begin
          clamp_int_r <= 1'b0;
        end else begin
          width_cnt_r <= width_cnt_r - 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // Clamp source and polarity
  // Device-chosen polarity is active high: the internal pulse is built so
  wire logic clamp_pos = !clamp_polarity_autooffset_ctrl_r[B_POL_OVR] ||
                         clamp_polarity_autooffset_ctrl_r[B_POL];
  wire logic ext_active = clamp_pos ? ext_clamp_sync : !ext_clamp_sync;
  wire logic clamp_nxt = coast_clamp_ctrl_r[B_CLAMP_SRC] ? ext_active :
                         clamp_int_r;

  // ==========================================================
  // Auto-offset pacing: counts clamp ends or vsyncs
  logic clamp_d_r;
  logic [7:0] ao_cnt_r;
  wire logic [1:0] ao_rate =
    clamp_polarity_autooffset_ctrl_r[B_RATE_HI:B_RATE_LO];
  wire logic clamp_end = clamp_d_r && !clamp_out;
  wire logic ao_on = clamp_polarity_autooffset_ctrl_r[B_AO_EN];
  wire logic [7:0] ao_limit = ao_rate == RATE_3 ? CLAMPS_3 :
                              ao_rate == RATE_48 ? CLAMPS_48 :
                              ao_rate == RATE_192 ? CLAMPS_192 :
                              VSYNCS_3;
  wire logic ao_event = ao_rate == 2'h3 ? vs_rise : clamp_end;
  wire logic ao_hit = ao_on && ao_event && ao_cnt_r >= ao_limit;

  // Counter held clear while disabled so the first update is a full period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clamp_d_r <= 1'b0;
      ao_cnt_r <= 8'h00;
    end else begin
      clamp_d_r <= clamp_out;
      if (!ao_on || ao_hit) begin
        ao_cnt_r <= 8'h00;
      end else if (ao_event) begin
        ao_cnt_r <= ao_cnt_r + 8'h01;
      end
    end
  end

  // ==========================================================
  // Sync-on-green output source and polarity
  wire logic [1:0] gs_src = green_sync_output_ctrl_r[B_GS_SEL_HI:B_GS_SEL_LO];
  wire logic gs_mux = gs_src == GS_RAW_GREEN ? gs_sel :
                      gs_src == GS_RAW_HSYNC ? hs_sel :
                      gs_src == GS_REGEN ? regen_hsync :
                      filtered_hsync;
  wire logic gs_nxt = green_sync_output_ctrl_r[B_GS_POL] ? gs_mux :
                      !gs_mux;

  // ==========================================================
  // Power-down: manual bit, or in auto mode either the pin or loss of every sync
  wire logic pin_pd = input_power_ctrl_r[B_PD_PIN_POL] ? pwrdn_sync :
                      !pwrdn_sync;
  wire logic pd_nxt = input_power_ctrl_r[B_PD_AUTO] ?
                      (pin_pd || sync_present == 2'h0) :
                      input_power_ctrl_r[B_PD];
  assign status_byte = {3'h0, power_down, channel_sel, auto_offset_en,
                        pend_r, clamp_out};

  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clamp_out <= 1'b0;
      red_clamp_mid <= 1'b0;
      green_clamp_mid <= 1'b0;
      blue_clamp_mid <= 1'b0;
      auto_offset_en <= 1'b0;
      offset_update <= 1'b0;
      green_sync_out_pin <= 1'b0;
      channel_sel <= 1'b0;
      power_down <= 1'b0;
    end else begin
      clamp_out <= clamp_nxt;
      red_clamp_mid <= coast_clamp_ctrl_r[B_RED_MID];
      green_clamp_mid <= coast_clamp_ctrl_r[B_GRN_MID];
      blue_clamp_mid <= coast_clamp_ctrl_r[B_BLU_MID];
      auto_offset_en <= ao_on;
      offset_update <= ao_hit;
      green_sync_out_pin <= gs_nxt;
      channel_sel <= ch_nxt;
      power_down <= pd_nxt;
    end
  end

  // ==========================================================
  // Assertions
  restart_clear_a: assert property (hs_fall |=> !clamp_int_r &&
    pend_r && delay_cnt_r == $past(clamp_start_delay_r))
    else $error("clamp not restarted on hsync trailing edge");
  clamp_start_a: assert property (pend_r && delay_cnt_r == 8'h00 &&
    !hs_fall && !width_zero |=> clamp_int_r && !pend_r)
    else $error("clamp did not start at placement count");
  clamp_width_a: assert property ($rose(clamp_int_r) &&
    $stable(clamp_width_count_r) |->
    width_cnt_r == clamp_width_count_r - 8'h01)
    else $error("clamp width count loaded wrong");
  clamp_src_a: assert property (coast_clamp_ctrl_r[B_CLAMP_SRC] &&
    $stable(coast_clamp_ctrl_r) |=> clamp_out == $past(ext_active))
    else $error("external clamp not followed");
  clamp_pol_a: assert property (coast_clamp_ctrl_r[B_CLAMP_SRC] &&
    clamp_polarity_autooffset_ctrl_r[B_POL_OVR:B_POL] == 2'h2 |=>
    clamp_out == !$past(ext_clamp_sync))
    else $error("clamp polarity override ignored");
  mid_select_a: assert property (##1 {red_clamp_mid, green_clamp_mid,
    blue_clamp_mid} == $past(coast_clamp_ctrl_r[B_RED_MID:B_BLU_MID]))
    else $error("clamp target select mismatch");
  offset_upd_a: assert property (offset_update |-> $past(ao_on) &&
    $past(ao_event) && $past(ao_cnt_r) == $past(ao_limit))
    else $error("offset update at wrong count");
  sync_out_a: assert property (gs_src == GS_RAW_HSYNC &&
    !green_sync_output_ctrl_r[B_GS_POL] |=>
    green_sync_out_pin == !$past(hs_sel))
    else $error("sync-on-green output route wrong");
  chan_ovr_a: assert property (input_power_ctrl_r[B_CH_OVR] |=>
    channel_sel == $past(input_power_ctrl_r[B_CH_SEL]))
    else $error("channel override ignored");
  pd_manual_a: assert property (!input_power_ctrl_r[B_PD_AUTO]
    |=> power_down == $past(input_power_ctrl_r[B_PD]))
    else $error("manual power-down not followed");
endmodule
`default_nettype wire

// ==== tb_clamp_offset_sync_out_control.sv ====
// Self-checking bench for the clamp, offset and sync-out control block.
// Assumes cosoc_pkg and cosoc_ctrl are compiled first; one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_clamp_offset_sync_out_control
  import cosoc_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic hready;
  logic [31:0] hrdata;
  logic hreadyout, hresp;
  logic [1:0] horiz_sync_pin = 2'h0;
  logic [1:0] green_sync_in_pin = 2'h0;
  logic [1:0] sync_present = 2'h1;
  logic ext_clamp_pin = 1'b0, vsync_pin = 1'b0, pwrdn_pin = 1'b1;
  logic regen_hsync = 1'b0, filtered_hsync = 1'b0;
  logic clamp_out, red_clamp_mid, green_clamp_mid, blue_clamp_mid;
  logic auto_offset_en, offset_update, green_sync_out_pin;
  logic channel_sel, power_down;
  int failures = 0;
  int comparisons = 0;
  int updates = 0;
  logic [7:0] ridx [7] = '{IDX_COAST_CLAMP, IDX_START_DELAY,
    IDX_WIDTH_COUNT, IDX_POL_OFFSET, IDX_TEST_ZERO, IDX_GSYNC_CTRL,
    IDX_INPUT_POWER};
  logic [7:0] rrst [7] = '{RST_COAST_CLAMP, RST_START_DELAY,
    RST_WIDTH_COUNT, RST_POL_OFFSET, RST_TEST_ZERO, RST_GSYNC_CTRL,
    RST_INPUT_POWER};
  logic [7:0] wval [7] = '{8'h2E, 8'hA5, 8'h5A, 8'hDB, 8'hFF, 8'h7F, 8'hA0};
  // Channel and power cases: control value, then {syncs, pin, chan, pd}
  logic [7:0] civ [9] = '{8'hE0, 8'hA0, 8'h60, 8'h28, 8'h20, 8'h30, 8'h30,
    8'h20, 8'h34};
  logic [4:0] cx [9] = '{5'h0A, 5'h10, 5'h1E, 5'h1D, 5'h00, 5'h1C, 5'h05,
    5'h12, 5'h1D};
  int lim [4] = '{3, 48, 192, 3};

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  always #12.5 hclk = ~hclk;

  // Pulses are one cycle wide, so each clock edge counts at most one
  always @(posedge hclk) begin
    if (offset_update === 1'b1) updates <= updates + 1;
  end

  cosoc_ctrl DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .horiz_sync_pin, .green_sync_in_pin, .ext_clamp_pin, .vsync_pin,
    .pwrdn_pin, .regen_hsync, .filtered_hsync, .sync_present, .clamp_out,
    .red_clamp_mid, .green_clamp_mid, .blue_clamp_mid, .auto_offset_en,
    .offset_update, .green_sync_out_pin, .channel_sel, .power_down);

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Counts: %0d mismatches, %0d comparisons", failures,
      comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Bus cycles: hold each phase until hready is seen high
  // No wait-state count is assumed; only the watchdog ends a stuck wait
  task automatic wait_ready();
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask

  task automatic bus(input logic [7:0] i, input logic w,
      input logic [7:0] v, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, i, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, v};
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    logic [31:0] x;
    bus(i, 1'b1, v, x);
  endtask

  // Registered outputs need the synchronisers and one register to land
  task automatic settle();
    repeat (4) @(posedge hclk);
    @(negedge hclk);
  endtask

  // One hsync pulse; clamp delay and width counted at falling edges
  task automatic measure(output int dly, output int wid);
    @(posedge hclk);
    horiz_sync_pin <= 2'h1;
    repeat (4) @(posedge hclk);
    horiz_sync_pin <= 2'h0;
    dly = 0;
    wid = 0;
    @(negedge hclk);
    while (clamp_out !== 1'b1 && dly < 600) begin
      @(negedge hclk);
      dly++;
    end
    while (clamp_out === 1'b1 && wid < 600) begin
      @(negedge hclk);
      wid++;
    end
  endtask

  task automatic pace(input int vs);
    int a, b;
    if (vs != 0) begin
      @(posedge hclk);
      vsync_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      vsync_pin <= 1'b0;
      repeat (4) @(posedge hclk);
    end else begin
      measure(a, b);
    end
  endtask

  // ==========================================================
  // Watchdog: the whole sequence needs about 9k cycles
  initial begin
    repeat (60000) @(posedge hclk);
    failures++;
    close_out();
  end

  // ==========================================================
  // Main sequence
  initial begin
    int d0, w0, d1, w1;
    logic [31:0] x;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ridx[i]) begin
      bus(ridx[i], 1'b0, 8'h00, x);
      check(x, {24'h0, rrst[i]});
    end
    foreach (ridx[i]) wr(ridx[i], wval[i]);
    wr(8'h05, 8'h77);
    foreach (ridx[i]) begin
      bus(ridx[i], 1'b0, 8'h00, x);
      check(x, {24'h0, wval[i]});
    end
    bus(8'h05, 1'b0, 8'h00, x);
    check(x, RDATA_ZERO);
    check(hresp, 1'b0);
    // Clamp targets, every combination of the three selects
    for (int k = 0; k < 8; k++) begin
      wr(IDX_COAST_CLAMP, 8'h20 | 8'(k << 1));
      settle();
      check({red_clamp_mid, green_clamp_mid, blue_clamp_mid}, k);
    end
    // Placement and duration, including values above 127
    wr(IDX_START_DELAY, 8'h04);
    wr(IDX_WIDTH_COUNT, 8'h05);
    measure(d0, w0);
    check(w0, 5);
    wr(IDX_START_DELAY, 8'hFF);
    wr(IDX_WIDTH_COUNT, 8'hC8);
    measure(d1, w1);
    check(d1 - d0, 251);
    check(w1, 200);
    wr(IDX_WIDTH_COUNT, 8'h00);
    measure(d1, w1);
    check(w1, 0);
    // External clamp source follows the pin, internal one ignored
    wr(IDX_COAST_CLAMP, 8'h30);
    @(posedge hclk);
    ext_clamp_pin <= 1'b1;
    settle();
    check(clamp_out, 1'b1);
    @(posedge hclk);
    ext_clamp_pin <= 1'b0;
    settle();
    check(clamp_out, 1'b0);
    // Polarity acts on the external clamp, so that source stays selected
    // Polarity: override negative, override positive, device choice
    wr(IDX_POL_OFFSET, 8'h9B);
    settle();
    check(clamp_out, 1'b1);
    wr(IDX_POL_OFFSET, 8'hDB);
    settle();
    check(clamp_out, 1'b0);
    wr(IDX_POL_OFFSET, 8'h1B);
    settle();
    check(clamp_out, 1'b0);
    wr(IDX_COAST_CLAMP, 8'h20);
    // Auto-offset pacing for every rate; disabling clears the count
    wr(IDX_START_DELAY, 8'h02);
    wr(IDX_WIDTH_COUNT, 8'h02);
    for (int r = 0; r < 4; r++) begin
      wr(IDX_POL_OFFSET, 8'h03 | 8'(r << 3));
      settle();
      check(auto_offset_en, 1'b0);
      updates = 0;
      repeat (4) pace(r == 3);
      settle();
      check(updates, 0);
      wr(IDX_POL_OFFSET, 8'h23 | 8'(r << 3));
      settle();
      check(auto_offset_en, 1'b1);
      updates = 0;
      repeat (2 * lim[r]) pace(r == 3);
      settle();
      check(updates, 2);
    end
    // Sync-out routing: only the chosen source moves the output
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 2; p++) begin
        wr(IDX_GSYNC_CTRL, 8'h78 | 8'(p << 2) | 8'(s));
        for (int l = 0; l < 2; l++) begin
          @(posedge hclk);
          {filtered_hsync, regen_hsync, horiz_sync_pin[0],
            green_sync_in_pin[0]} <= l ? 4'(1 << s) : ~4'(1 << s);
          settle();
          check(green_sync_out_pin, l == p);
        end
      end
    end
    // Channel choice and power-down, manual and automatic
    foreach (civ[i]) begin
      wr(IDX_INPUT_POWER, civ[i]);
      @(posedge hclk);
      sync_present <= cx[i][4:3];
      pwrdn_pin <= cx[i][2];
      settle();
      check(channel_sel, cx[i][1]);
      check(power_down, cx[i][0]);
    end
    close_out();
  end
endmodule
`default_nettype wire
